// File: logic/bep_pkg.sv
package bep_pkg;
   // Register byte offsets on the APB port.
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_PATLEN = 8'h04;
   localparam logic [7:0] OFS_FPOS = 8'h08;
   localparam logic [7:0] OFS_START = 8'h0C;
   localparam logic [7:0] OFS_STOP = 8'h10;
   localparam logic [7:0] OFS_THR = 8'h14;
   localparam logic [7:0] OFS_DISP = 8'h18;
   localparam logic [7:0] OFS_PADDR = 8'h1C;
   localparam logic [7:0] OFS_PDATA = 8'h20;
   localparam logic [7:0] OFS_STAT = 8'h24;
   localparam logic [7:0] OFS_ERRS = 8'h28;
   localparam logic [7:0] OFS_BITS = 8'h2C;
   // Control and threshold register field positions.
   localparam int CTL_ENABLE = 0;
   localparam int CTL_INVPOL = 1;
   localparam int CTL_SEL_LO = 2;
   localparam int CTL_PROG = 4;
   localparam int CTL_PRBS_LO = 5;
   localparam int CTL_WORD = 8;
   localparam int CTL_RESYNC = 9;
   localparam int THR_ATT_LO = 16;
   // Reset values.
   localparam logic [20:0] PATLEN_RST = 21'h000080;
   localparam logic [20:0] FPOS_RST = 21'h000001;
   localparam logic [31:0] START_RST = 32'h00000001;
   localparam logic [31:0] STOP_RST = 32'h00000001;
   // Sizes.
   localparam int IDX_W = 21;
   localparam int PAT_BITS_MAX = 1305600;
   localparam logic [20:0] WORD_BITS = 21'h000040;
   localparam logic [20:0] WORD_MIN_LEN = 21'h000080;
   localparam logic [4:0] ATT_MAX_DB = 5'h1E;
   localparam int GAIN_FRAC = 8;
   // Input source selections.
   localparam logic [1:0] SEL_DIFF = 2'h0;
   localparam logic [1:0] SEL_TRUE = 2'h1;
   localparam logic [1:0] SEL_COMP = 2'h2;
   localparam logic [1:0] SEL_OPT = 2'h3;
   // Ten to the power of dB over 20, in units of 1/256, for 0 to 30 dB.
   localparam logic [15:0] ATT_GAIN [0:30] = '{
      16'h0100, 16'h011F, 16'h0142, 16'h016A, 16'h0196, 16'h01C7, 16'h01FF, 16'h023D,
      16'h0283, 16'h02D2, 16'h032A, 16'h038C, 16'h03FB, 16'h0477, 16'h0503, 16'h05A0,
      16'h064F, 16'h0714, 16'h07F1, 16'h08E9, 16'h0A00, 16'h0B38, 16'h0C97, 16'h0E20,
      16'h0FD9, 16'h11C8, 16'h13F3, 16'h1662, 16'h191E, 16'h1C2E, 16'h1F9F};
   typedef enum logic [2:0] {ST_IDLE, ST_LOAD, ST_HUNT, ST_VERIFY, ST_LOCKED} bep_state_t;
endpackage : bep_pkg

// File: logic/bep_pattern_mem.sv
`timescale 1ns/1ps
module bep_pattern_mem #(
   parameter int BYTES = 163200,
   parameter int AW = 18
) (
   input wire logic clock,
   input wire logic wrEn,
   input wire logic [AW-1:0] wrAddr,
   input wire logic [7:0] wrData,
   input wire logic [20:0] rdIdx,
   output logic rdBit
);
   logic [7:0] mem [0:BYTES-1];
   logic [7:0] rdByte;
   logic [AW-1:0] rdAddr;

   // Bytes run in ascending address order, most significant bit first.
   assign rdAddr = rdIdx[AW+2:3];
   assign rdByte = (int'(rdAddr) < BYTES) ? mem[rdAddr] : 8'h00;
   assign rdBit = rdByte[3'h7 - rdIdx[2:0]];

   // Storage has no reset; software loads it before use.
   always_ff @(posedge clock) begin
      if (wrEn && int'(wrAddr) < BYTES) begin
         mem[wrAddr] <= wrData;
      end
   end
endmodule : bep_pattern_mem

// File: logic/bep_sync_core.sv
// The address map and register access over APB are this design's own decisions.
`timescale 1ns/1ps
// What this block does
// - Every compared bit differing from the reference counts as one bit error.
// - Negative logic inverts received bits before comparison.
// - Source is differential, true only, complement only, or optical input.
// - Displayed threshold equals set threshold times ten to attenuation over 20.
// - Pseudo-random reference is seeded from received bits to predict the next.
// - Word mode off with stored pattern searches by whole-pattern comparison.
// - Word mode on, length 128 or more, hunts the 64 bits at start position.
// - After the word matches, comparison resumes with the 65th bit counted from the start position.
// - Word mode with length 127 or less ignores the word, whole-pattern search.
// - After a candidate, a full pattern is compared; sync only below threshold.
// - Start position is one-based; position 1 is bit 7, the most significant bit, of byte 0.
// - Each matching word occurrence is tried in turn.
// - Any candidate below threshold is declared synced, even a wrong one.
// - Auto resync restarts on rate above threshold; off, never resyncs.
// - Start and stop levels both reset to 1; lock needs fewer than stop, loss more than start, giving hysteresis.
// - Stored pattern holds at most 1305600 bits; excess is dropped.
module bep_sync_core #(
   parameter int PAT_BITS = bep_pkg::PAT_BITS_MAX
) (
   input wire logic clock,
   input wire logic nrst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic dataTrue,
   input wire logic complementInput,
   input wire logic dataOptical,
   input wire logic bitStrobe,
   output logic syncLocked,
   output logic bitError
);
   localparam int BYTES = PAT_BITS / 8;
   localparam int AW = $clog2(BYTES);

   // The index width and byte layout limit what the store can hold.
   // A length of 2**21 itself would wrap to zero in the 21-bit length register.
   if (PAT_BITS % 8 != 0 || PAT_BITS < 128 || PAT_BITS >= 2 ** bep_pkg::IDX_W) begin : g_badSize
      $error("PAT_BITS must be a multiple of 8, at least 128 and below 2**21");
   end

   function automatic logic [20:0] wrapInc(input logic [20:0] v, input logic [20:0] len);
      wrapInc = (v + 21'h000001 >= len) ? 21'h000000 : v + 21'h000001;
   endfunction : wrapInc

   function automatic logic prbsFb(input logic [30:0] s, input logic [2:0] sel);
      case (sel)
         3'h0: prbsFb = s[6] ^ s[5];
         3'h1: prbsFb = s[8] ^ s[4];
         3'h2: prbsFb = s[14] ^ s[13];
         3'h3: prbsFb = s[22] ^ s[17];
         default: prbsFb = s[30] ^ s[27];
      endcase
   endfunction : prbsFb

   function automatic logic [31:0] prbsLen(input logic [2:0] sel);
      case (sel)
         3'h0: prbsLen = 32'h0000007F;
         3'h1: prbsLen = 32'h000001FF;
         3'h2: prbsLen = 32'h00007FFF;
         3'h3: prbsLen = 32'h007FFFFF;
         default: prbsLen = 32'h7FFFFFFF;
      endcase
   endfunction : prbsLen

   logic [1:0] rstPipe_r;
   logic rstn;
   logic [3:0] pinS1_r;
   logic [3:0] pinS2_r;
   logic strobeOld_r;
   logic lastDiff_r;
   logic enable_r;
   logic invPol_r;
   logic [1:0] inSel_r;
   logic progMode_r;
   logic [2:0] prbsSel_r;
   logic wordOn_r;
   logic autoResync_r;
   logic [20:0] patLen_r;
   logic [20:0] fpos_r;
   logic [31:0] startErrs_r;
   logic [31:0] stopErrs_r;
   logic signed [15:0] thr_r;
   logic [4:0] att_r;
   logic signed [31:0] disp_r;
   logic [AW-1:0] pAddr_r;
   logic pready_r;
   logic pslverr_r;
   logic [31:0] prdata_r;
   bep_pkg::bep_state_t state_r;
   bep_pkg::bep_state_t state_nxt;
   logic [30:0] lfsr_r;
   logic [63:0] rxShift_r;
   logic [63:0] word_r;
   logic [5:0] loadCnt_r;
   logic [20:0] ptr_r;
   logic [31:0] winBits_r;
   logic [31:0] winErrs_r;
   logic [31:0] errTotal_r;
   logic [31:0] bitTotal_r;
   logic locked_r;
   logic bitErr_r;

   // Reset is released through two flops so every flop reset by rstn leaves reset together.
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         rstPipe_r <= 2'h0;
      end else begin
         rstPipe_r <= {rstPipe_r[0], 1'b1};
      end
   end
   assign rstn = rstPipe_r[1];

   // Pins come from the generator's domain, so two flops before any use.
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         pinS1_r <= 4'h0;
         pinS2_r <= 4'h0;
         strobeOld_r <= 1'b0;
      end else begin
         pinS1_r <= {bitStrobe, dataOptical, complementInput, dataTrue};
         pinS2_r <= pinS1_r;
         strobeOld_r <= pinS2_r[3];
      end
   end

   // Bit decision and polarity.
   logic bitTick;
   logic decided;
   logic diffBit;
   logic rxBit;
   assign bitTick = pinS2_r[3] & ~strobeOld_r & enable_r;
   assign diffBit = (pinS2_r[0] != pinS2_r[1]) ? pinS2_r[0] : lastDiff_r;
   assign decided = (inSel_r == bep_pkg::SEL_DIFF) ? diffBit :
                    (inSel_r == bep_pkg::SEL_TRUE) ? pinS2_r[0] :
                    (inSel_r == bep_pkg::SEL_COMP) ? ~pinS2_r[1] : pinS2_r[2];
   assign rxBit = decided ^ invPol_r;

   // Equal inputs carry no difference, so the last decision is held.
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         lastDiff_r <= 1'b0;
      end else if (bitTick) begin
         lastDiff_r <= diffBit;
      end
   end

   // APB decode; the access phase always takes one wait cycle.
   logic apbAcc;
   logic apbWr;
   logic [7:0] ofs;
   logic mapped;
   logic [31:0] rdMux;
   logic [31:0] ctrlView;
   assign apbAcc = psel & penable & ~pready_r;
   assign apbWr = psel & penable & pwrite & pready_r & mapped; // Unmapped writes must not alias low offsets.
   assign ofs = paddr[7:0];
   assign mapped = (paddr[31:8] == 24'h000000) && (ofs[1:0] == 2'h0) && (ofs <= bep_pkg::OFS_BITS);
   assign ctrlView = {22'h000000, autoResync_r, wordOn_r, prbsSel_r, progMode_r, inSel_r, invPol_r, enable_r};
   assign rdMux = (ofs == bep_pkg::OFS_CTRL) ? ctrlView :
                  (ofs == bep_pkg::OFS_PATLEN) ? {11'h000, patLen_r} :
                  (ofs == bep_pkg::OFS_FPOS) ? {11'h000, fpos_r} :
                  (ofs == bep_pkg::OFS_START) ? startErrs_r :
                  (ofs == bep_pkg::OFS_STOP) ? stopErrs_r :
                  (ofs == bep_pkg::OFS_THR) ? {11'h000, att_r, thr_r} :
                  (ofs == bep_pkg::OFS_DISP) ? disp_r :
                  (ofs == bep_pkg::OFS_PADDR) ? 32'(pAddr_r) :
                  (ofs == bep_pkg::OFS_STAT) ? {28'h0000000, 1'b0, 3'(state_r)} | {31'h0, locked_r} << 4 :
                  (ofs == bep_pkg::OFS_ERRS) ? errTotal_r :
                  (ofs == bep_pkg::OFS_BITS) ? bitTotal_r : 32'h00000000;

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         pready_r <= 1'b0;
         pslverr_r <= 1'b0;
         prdata_r <= 32'h00000000;
      end else begin
         pready_r <= apbAcc;
         pslverr_r <= apbAcc & ~mapped;
         prdata_r <= (apbAcc && !pwrite && mapped) ? rdMux : 32'h00000000;
      end
   end

   // Configuration writes; pattern length is clipped to the store size.
   logic [20:0] lenReq;
   assign lenReq = (int'(pwdata[20:0]) > PAT_BITS) ? 21'(PAT_BITS) : pwdata[20:0];
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         {enable_r, invPol_r, progMode_r, wordOn_r, autoResync_r} <= 5'h00;
         inSel_r <= bep_pkg::SEL_DIFF;
         prbsSel_r <= 3'h0;
         patLen_r <= bep_pkg::PATLEN_RST;
         fpos_r <= bep_pkg::FPOS_RST;
         startErrs_r <= bep_pkg::START_RST;
         stopErrs_r <= bep_pkg::STOP_RST;
         thr_r <= 16'sh0000;
         att_r <= 5'h00;
         pAddr_r <= '0;
      end else if (apbWr) begin
         case (ofs)
            bep_pkg::OFS_CTRL: begin
               enable_r <= pwdata[bep_pkg::CTL_ENABLE];
               invPol_r <= pwdata[bep_pkg::CTL_INVPOL];
               inSel_r <= pwdata[bep_pkg::CTL_SEL_LO +: 2];
               progMode_r <= pwdata[bep_pkg::CTL_PROG];
               prbsSel_r <= pwdata[bep_pkg::CTL_PRBS_LO +: 3];
               wordOn_r <= pwdata[bep_pkg::CTL_WORD];
               autoResync_r <= pwdata[bep_pkg::CTL_RESYNC];
            end
            bep_pkg::OFS_PATLEN: patLen_r <= lenReq;
            bep_pkg::OFS_FPOS: fpos_r <= pwdata[20:0];
            bep_pkg::OFS_START: startErrs_r <= pwdata;
            bep_pkg::OFS_STOP: stopErrs_r <= pwdata;
            bep_pkg::OFS_THR: begin
               thr_r <= pwdata[15:0];
               att_r <= (pwdata[20:16] > bep_pkg::ATT_MAX_DB) ? bep_pkg::ATT_MAX_DB : pwdata[20:16];
            end
            bep_pkg::OFS_PADDR: pAddr_r <= pwdata[AW-1:0];
            bep_pkg::OFS_PDATA: pAddr_r <= AW'(pAddr_r + 1'b1);
            default: pAddr_r <= pAddr_r;
         endcase
      end
   end

   // Displayed threshold, kept registered so a read sees a settled value.
   logic signed [31:0] dispNext;
   assign dispNext = (32'(thr_r) * $signed({16'h0000, bep_pkg::ATT_GAIN[att_r]})) >>> bep_pkg::GAIN_FRAC;
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         disp_r <= 32'sh00000000;
      end else begin
         disp_r <= dispNext;
      end
   end

   // Pattern store; bytes beyond its size are dropped.
   logic memBit;
   logic [20:0] memIdx;
   logic [20:0] wordIdx;
   assign wordIdx = fpos_r - 21'h000001 + 21'(loadCnt_r);
   assign memIdx = (state_r == bep_pkg::ST_LOAD) ? wordIdx : ptr_r;
   bep_pattern_mem #(.BYTES(BYTES), .AW(AW)) u_mem (
      .clock(clock),
      .wrEn(apbWr && ofs == bep_pkg::OFS_PDATA),
      .wrAddr(pAddr_r),
      .wrData(pwdata[7:0]),
      .rdIdx(memIdx),
      .rdBit(memBit)
   );

   // Comparison and window bookkeeping.
   logic fullMode;
   logic refBit;
   logic miss;
   logic comparing;
   logic [31:0] winLen;
   logic winEnd;
   logic [31:0] errsNow;
   logic wordHit;
   logic [20:0] afterWord;
   logic [20:0] ptrInc;
   assign fullMode = ~wordOn_r | (patLen_r < bep_pkg::WORD_MIN_LEN);
   assign refBit = progMode_r ? memBit : prbsFb(lfsr_r, prbsSel_r);
   assign miss = rxBit ^ refBit;
   assign comparing = (state_r == bep_pkg::ST_VERIFY) || (state_r == bep_pkg::ST_LOCKED);
   assign winLen = progMode_r ? {11'h000, patLen_r} : prbsLen(prbsSel_r);
   assign winEnd = bitTick & comparing & (winBits_r == winLen - 32'h00000001);
   assign errsNow = winErrs_r + {31'h0, miss};
   assign wordHit = bitTick & ({rxShift_r[62:0], rxBit} == word_r);
   assign ptrInc = wrapInc(ptr_r, patLen_r);
   assign afterWord = wrapInc(fpos_r - 21'h000001 + bep_pkg::WORD_BITS - 21'h000001, patLen_r);

   // Acquisition sequence.
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         bep_pkg::ST_IDLE: begin
            if (enable_r) begin
               state_nxt = (progMode_r && !fullMode) ? bep_pkg::ST_LOAD : bep_pkg::ST_VERIFY;
            end
         end
         bep_pkg::ST_LOAD: begin
            if (loadCnt_r == 6'h3F) begin
               state_nxt = bep_pkg::ST_HUNT;
            end
         end
         bep_pkg::ST_HUNT: begin
            if (wordHit) begin
               state_nxt = bep_pkg::ST_VERIFY;
            end
         end
         bep_pkg::ST_VERIFY: begin
            if (winEnd && errsNow < stopErrs_r) begin
               state_nxt = bep_pkg::ST_LOCKED;
            end else if (winEnd && progMode_r && !fullMode) begin
               state_nxt = bep_pkg::ST_HUNT;
            end
         end
         bep_pkg::ST_LOCKED: begin
            if (winEnd && autoResync_r && errsNow > startErrs_r) begin
               state_nxt = bep_pkg::ST_IDLE;
            end
         end
         default: state_nxt = bep_pkg::ST_IDLE;
      endcase
      if (!enable_r) begin
         state_nxt = bep_pkg::ST_IDLE;
      end
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         state_r <= bep_pkg::ST_IDLE;
         loadCnt_r <= 6'h00;
         word_r <= 64'h0000000000000000;
      end else begin
         state_r <= state_nxt;
         loadCnt_r <= (state_r == bep_pkg::ST_LOAD) ? loadCnt_r + 6'h01 : 6'h00;
         if (state_r == bep_pkg::ST_LOAD) begin
            word_r <= {word_r[62:0], memBit};
         end
      end
   end

   // The generator shifts once per received bit; the pattern pointer steps once per compared bit, twice after a failed full-pattern window.
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         lfsr_r <= 31'h00000000;
         rxShift_r <= 64'h0000000000000000;
         ptr_r <= 21'h000000;
      end else if (state_r == bep_pkg::ST_IDLE) begin
         ptr_r <= 21'h000000;
      end else if (bitTick) begin
         rxShift_r <= {rxShift_r[62:0], rxBit};
         if (state_r == bep_pkg::ST_LOCKED) begin
            lfsr_r <= {lfsr_r[29:0], refBit};
         end else begin
            lfsr_r <= {lfsr_r[29:0], rxBit};
         end
         if (wordHit && state_r == bep_pkg::ST_HUNT) begin
            ptr_r <= afterWord;
         end else if (winEnd && state_nxt == bep_pkg::ST_VERIFY && fullMode) begin
            ptr_r <= wrapInc(ptrInc, patLen_r);
         end else if (comparing) begin
            ptr_r <= ptrInc;
         end
      end
   end

   // Error and bit counters.
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         winBits_r <= 32'h00000000;
         winErrs_r <= 32'h00000000;
         errTotal_r <= 32'h00000000;
         bitTotal_r <= 32'h00000000;
         locked_r <= 1'b0;
         bitErr_r <= 1'b0;
      end else begin
         locked_r <= (state_nxt == bep_pkg::ST_LOCKED);
         bitErr_r <= bitTick & (state_r == bep_pkg::ST_LOCKED) & miss;
         if (!comparing || winEnd) begin
            winBits_r <= 32'h00000000;
            winErrs_r <= 32'h00000000;
         end else if (bitTick) begin
            winBits_r <= winBits_r + 32'h00000001;
            winErrs_r <= errsNow;
         end
         if (bitTick && state_r == bep_pkg::ST_LOCKED) begin
            bitTotal_r <= bitTotal_r + 32'h00000001;
            errTotal_r <= errTotal_r + {31'h0, miss};
         end
      end
   end

   assign prdata = prdata_r;
   assign pready = pready_r;
   assign pslverr = pslverr_r;
   assign syncLocked = locked_r;
   assign bitError = bitErr_r;

   a_error_count: assert property (@(posedge clock) disable iff (!rstn)
      bitTick && state_r == bep_pkg::ST_LOCKED && miss |=> errTotal_r == $past(errTotal_r) + 32'h00000001)
      else $error("mismatch not counted");
   a_neg_invert: assert property (@(posedge clock) disable iff (!rstn)
      inSel_r == bep_pkg::SEL_TRUE |-> rxBit == (pinS2_r[0] ^ invPol_r))
      else $error("polarity not applied");
   a_comp_source: assert property (@(posedge clock) disable iff (!rstn)
      inSel_r == bep_pkg::SEL_COMP && !invPol_r |-> rxBit != pinS2_r[1])
      else $error("complement source wrong");
   a_disp_thresh: assert property (@(posedge clock) disable iff (!rstn)
      att_r == 5'h14 && $stable(att_r) && $stable(thr_r) |=> disp_r == 32'(thr_r) * 10)
      else $error("displayed threshold wrong");
   a_prbs_seed: assert property (@(posedge clock) disable iff (!rstn)
      bitTick && state_r == bep_pkg::ST_VERIFY |=> lfsr_r[0] == $past(rxBit))
      else $error("generator not seeded");
   a_word_entry: assert property (@(posedge clock) disable iff (!rstn)
      state_r == bep_pkg::ST_HUNT && wordHit && enable_r |=> state_r == bep_pkg::ST_VERIFY && ptr_r == $past(afterWord))
      else $error("word entry wrong");
   a_short_full: assert property (@(posedge clock) disable iff (!rstn)
      fullMode |-> state_r != bep_pkg::ST_HUNT ##1 state_r != bep_pkg::ST_LOAD)
      else $error("word used in full mode");
   a_lock_rate: assert property (@(posedge clock) disable iff (!rstn)
      state_r == bep_pkg::ST_VERIFY && state_nxt == bep_pkg::ST_LOCKED |-> winEnd && errsNow < stopErrs_r ##1 locked_r)
      else $error("lock without low rate");
   a_resync_off: assert property (@(posedge clock) disable iff (!rstn)
      state_r == bep_pkg::ST_LOCKED && !autoResync_r && enable_r |=> state_r == bep_pkg::ST_LOCKED)
      else $error("resync while disabled");
   a_len_limit: assert property (@(posedge clock) disable iff (!rstn)
      int'(patLen_r) <= PAT_BITS)
      else $error("pattern length over limit");
endmodule : bep_sync_core

// File: verification/bep_pattern_source.sv
`timescale 1ns/1ps
module bep_pattern_source (
   input wire logic clock,
   input wire logic nrst,
   input wire logic [127:0] pattern,
   input wire logic inv,
   input wire logic prbsMode,
   input wire logic errReq,
   output logic dataTrue,
   output logic complementInput,
   output logic dataOptical,
   output logic bitStrobe
);
   logic [2:0] phase_r;
   logic [6:0] idx_r;
   logic cur_r;
   logic errPend_r;
   logic [6:0] gen_r;
   logic genBit;

   // Seven-stage generator tapped at its last two stages, the shortest pseudo-random choice.
   assign genBit = gen_r[6] ^ gen_r[5];

   // The same decided bit reaches every input, so any source selection sees the stream.
   assign dataTrue = cur_r;
   assign complementInput = ~cur_r;
   assign dataOptical = cur_r;

   // Data changes one clock before the strobe rises, so it is through the synchronisers one clock before the strobe edge.
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         phase_r <= 3'h0;
         idx_r <= 7'h00;
         cur_r <= 1'b0;
         errPend_r <= 1'b0;
         bitStrobe <= 1'b0;
         gen_r <= 7'h7F;
      end else begin
         phase_r <= (phase_r == 3'h5) ? 3'h0 : phase_r + 3'h1;
         bitStrobe <= (phase_r != 3'h0) && (phase_r < 3'h4);
         if (phase_r == 3'h0) begin
            cur_r <= (prbsMode ? genBit : pattern[7'h7F - idx_r]) ^ inv ^ errPend_r;
            gen_r <= {gen_r[5:0], genBit};
            idx_r <= idx_r + 7'h01;
            errPend_r <= errReq;
         end else begin
            errPend_r <= errPend_r | errReq;
         end
      end
   end
endmodule : bep_pattern_source

// File: verification/bep_sync_core_tb_top.sv
`timescale 1ns/1ps
module bep_sync_core_tb_top;
   logic clock, nrst, psel, penable, pwrite, pready, pslverr, err, inv, errReq, prbsMode;
   logic [31:0] paddr, pwdata, prdata, rd;
   logic dataTrue, complementInput, dataOptical, bitStrobe, syncLocked, bitError;
   logic [127:0] pattern;
   int miscompares, check_count, pulses;

   bep_sync_core #(.PAT_BITS(1024)) dut (.clock(clock), .nrst(nrst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .dataTrue(dataTrue), .complementInput(complementInput), .dataOptical(dataOptical),
      .bitStrobe(bitStrobe), .syncLocked(syncLocked), .bitError(bitError));
   bep_pattern_source src (.clock(clock), .nrst(nrst), .pattern(pattern), .inv(inv), .errReq(errReq),
      .prbsMode(prbsMode),
      .dataTrue(dataTrue), .complementInput(complementInput), .dataOptical(dataOptical),
      .bitStrobe(bitStrobe));

   // Clock at 40 MHz.
   initial begin
      clock = 1'b0;
      forever #12.5 clock = ~clock;
   end

   // Error pulses last one clock, so they are counted at every edge.
   always @(posedge clock) begin
      if (bitError === 1'b1) pulses++;
   end

   task automatic wrap_up;
      $display("miscompares=%0d check_count=%0d", miscompares, check_count);
      if (miscompares == 0 && check_count > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : wrap_up

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         miscompares++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   // One APB transfer; the request holds until pready is seen at an edge, and only the watchdog ends a hang.
   task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= {24'h000000, a};
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      do begin
         @(posedge clock);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clock);
   endtask : xfer

   task automatic waitLock(input logic exp);
      int n;
      n = 0;
      while (syncLocked !== exp && n < 9000) begin
         @(posedge clock);
         n++;
      end
      chk({31'h0, syncLocked}, {31'h0, exp});
   endtask : waitLock

   // Main sequence: register defaults, threshold display, then lock, errors and loss of sync.
   initial begin
      int k;
      {nrst, psel, penable, pwrite, inv, errReq, prbsMode} = 7'h00;
      paddr = 32'h00000000;
      pwdata = 32'h00000000;
      pattern = 128'h000102030405060708090A0B0C0D0E0F;
      miscompares = 0;
      check_count = 0;
      pulses = 0;
      repeat (20) @(posedge clock);
      nrst <= 1'b1;
      repeat (3) @(posedge clock);
      xfer(1'b0, bep_pkg::OFS_PATLEN, 32'h0);
      chk(rd, {11'h000, bep_pkg::PATLEN_RST});
      xfer(1'b0, bep_pkg::OFS_FPOS, 32'h0);
      chk(rd, {11'h000, bep_pkg::FPOS_RST});
      xfer(1'b0, bep_pkg::OFS_START, 32'h0);
      chk(rd, bep_pkg::START_RST);
      xfer(1'b0, 8'h30, 32'h0);
      chk({31'h0, err}, 32'h00000001);
      xfer(1'b1, bep_pkg::OFS_THR, 32'h00140064);
      xfer(1'b0, bep_pkg::OFS_DISP, 32'h0);
      chk(rd, 32'h000003E8);
      xfer(1'b1, bep_pkg::OFS_PADDR, 32'h0);
      for (k = 0; k < 16; k++) xfer(1'b1, bep_pkg::OFS_PDATA, 32'(k));
      // Every source and polarity; the word at position 1 occurs once and one stray error blocks lock.
      for (k = 0; k < 8; k++) begin
         inv <= k[0];
         xfer(1'b1, bep_pkg::OFS_CTRL, {22'h0, 6'h11, k[2:1], k[0], 1'b0});
         xfer(1'b1, bep_pkg::OFS_CTRL, {22'h0, 6'h11, k[2:1], k[0], 1'b1});
         waitLock(1'b1);
      end
      xfer(1'b0, bep_pkg::OFS_STAT, 32'h0);
      chk(rd, 32'h00000014);
      pulses = 0;
      errReq <= 1'b1;
      @(posedge clock);
      errReq <= 1'b0;
      repeat (200) @(posedge clock);
      chk(32'(pulses), 32'h00000001);
      xfer(1'b0, bep_pkg::OFS_ERRS, 32'h0);
      chk(rd, 32'h00000001);
      // A long error burst keeps lock while resync is off, and drops it once resync is on.
      errReq <= 1'b1;
      repeat (1600) @(posedge clock);
      chk({31'h0, syncLocked}, 32'h00000001);
      xfer(1'b1, bep_pkg::OFS_CTRL, 32'h0000031F);
      waitLock(1'b0);
      errReq <= 1'b0;
      waitLock(1'b1);
      // Pseudo-random reference: the generator switches while the checker is off, then the checker seeds itself.
      xfer(1'b1, bep_pkg::OFS_CTRL, 32'h00000000);
      prbsMode <= 1'b1;
      inv <= 1'b0;
      xfer(1'b1, bep_pkg::OFS_CTRL, 32'h00000001);
      waitLock(1'b1);
      wrap_up;
   end

   // Watchdog sized well above the expected run of under 20000 clocks.
   initial begin
      repeat (90000) @(posedge clock);
      miscompares++;
      wrap_up;
   end
endmodule : bep_sync_core_tb_top
